// ### core/nrbi_host.sv
// Notes on behaviour
// - Shared open-drain line; host reads any low as some target busy.
// - Each die has its own status register, pollable instead of the line.
// - No reset command before the line is valid and high after power-up.
// - Unmonitored: wait 100 us after supply good; monitored: wait line high.
// - Reset code ff is the first command to every target after power-on.
// - Target busy 1 ms after reset; track by line or status polling.
// - Identification commands take one address; not issued while busy.
// - Get features one address; set features one address and 4 data.
// - Random data read: 05, two columns, e0; not while selected die busy (host refuses it whenever the line is low).
// - Command latched on rising write strobe, select low, cle high, ale low.
`timescale 1ns/1ps
`default_nettype none
module nrbi_host
    import nrbi_pkg::*;
#(
    parameter logic [WAIT_W-1:0] T_VALID_CYC = WAIT_W'(T_VALID_US * CLK_MHZ),
    parameter logic [WAIT_W-1:0] T_PWR_CYC   = WAIT_W'(T_PWR_US * CLK_MHZ),
    parameter logic [WAIT_W-1:0] T_RST_CYC   = WAIT_W'(T_RST_US * CLK_MHZ)
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       rb_used_i,
    input  wire logic       req_valid_i,
    input  wire nrbi_req_t  req_i,
    output logic            req_ready_o,
    output logic            done_o,
    output logic            err_o,
    output logic [7:0]      rdata_o,
    output logic            init_done_o,
    output logic            busy_o,
    output logic            ce_n_o,
    output logic            cle_o,
    output logic            ale_o,
    output logic            we_n_o,
    output logic            read_strobe_n_o,
    output logic [7:0]      io_o,
    output logic            io_oe_o,
    input  wire logic [7:0] io_i,
    input  wire logic       ready_busy_n_i
);

    typedef struct packed {
        nrbi_state_t      state;
        logic [CNT_W-1:0] cnt;
        logic [1:0]       idx;
        nrbi_req_t        req;
        nrbi_pins_t       pin;
        logic             rb_s1;
        logic             rb_s2;
        logic [7:0]       io_s1;
        logic [7:0]       io_s2;
        logic             busy;
        logic             req_ready;
        logic             done;
        logic             err;
        logic [7:0]       rdata;
        logic             init_done;
    } nrbi_host_st_t;

    nrbi_host_st_t     q;
    nrbi_host_st_t     next_q;
    logic              w_load;
    logic [WAIT_W-1:0] w_count;
    logic              w_expired;

    nrbi_wait u_wait (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_i),
        .load_i    (w_load),
        .count_i   (w_count),
        .expired_o (w_expired)
    );

    // ------------------------------------------------------------
    // Phase launch
    // ------------------------------------------------------------
    // set pin levels for the next phase
    function automatic nrbi_host_st_t launch(input nrbi_host_st_t s, input nrbi_state_t nx);
        nrbi_host_st_t r;
        r                   = s;
        r.state             = nx;
        r.cnt               = '0;
        r.pin.ce_n          = 1'b0;
        r.pin.cle           = (nx == S_CMD) || (nx == S_CONF);
        r.pin.ale           = (nx == S_ADDR);
        r.pin.read_strobe_n = 1'b1;
        r.pin.io_oe         = (nx != S_READ) && (nx != S_FINISH);
        r.pin.we_n          = !r.pin.io_oe;
        case (nx)
            S_CMD:   r.pin.io = s.req.cmd;
            S_ADDR:  r.pin.io = s.req.addr[8*s.idx +: 8];
            S_DATA:  r.pin.io = s.req.wdata[8*s.idx +: 8];
            S_CONF:  r.pin.io = s.req.conf;
            default: r.pin.io = 8'h00;
        endcase
        return r;
    endfunction

    // Order: command, addresses, data, confirm, read back
    function automatic nrbi_state_t after(input nrbi_host_st_t s);
        if (s.state == S_CMD && s.req.n_addr != 2'h0) begin
            return S_ADDR;
        end
        if ((s.state == S_CMD || s.state == S_ADDR) && s.req.n_data != 3'h0) begin
            return S_DATA;
        end
        if (s.state != S_CONF && s.req.conf_en) begin
            return S_CONF;
        end
        if (s.req.rd_en) begin
            return S_READ;
        end
        return S_FINISH;
    endfunction

    function automatic logic busy_blocked(input logic [7:0] c);
        return (c == CMD_READ_ID) || (c == CMD_PARAM_PAGE) || (c == CMD_UNIQUE_ID)
            || (c == CMD_GET_FEAT) || (c == CMD_SET_FEAT) || (c == CMD_RAND_READ);
    endfunction

    logic wr_last;
    logic more;
    assign wr_last = (q.cnt == CNT_W'(WP_CYC + WH_CYC - 1));

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_q       = q;
        w_load       = 1'b0;
        w_count      = '0;
        more         = 1'b0;
        next_q.done  = 1'b0;
        next_q.err   = 1'b0;
        next_q.rb_s1 = ready_busy_n_i;
        next_q.rb_s2 = q.rb_s1;
        next_q.io_s1 = io_i;
        next_q.io_s2 = q.io_s1;
        next_q.busy  = !q.rb_s2;
        if (q.state inside {S_CMD, S_ADDR, S_DATA}) begin
            next_q.cnt = q.cnt + 1'b1;
            if (q.cnt == CNT_W'(WP_CYC - 1)) begin
                next_q.pin.we_n = 1'b1;
            end
        end
        case (q.state)
            S_PWR_START: begin
                w_load       = 1'b1;
                w_count      = T_VALID_CYC;
                next_q.state = S_PWR_VALID;
            end
            S_PWR_VALID: begin
                if (w_expired) begin
                    w_load       = 1'b1;
                    w_count      = T_PWR_CYC;
                    next_q.state = S_PWR_RDY;
                end
            end
            S_PWR_RDY: begin
                if (rb_used_i ? q.rb_s2 : w_expired) begin
                    next_q.req     = '0;
                    next_q.req.cmd = CMD_RESET;
                    next_q         = launch(next_q, S_CMD);
                end
            end
            S_RST_WAIT: begin
                if (q.cnt != CNT_W'(WB_CYC)) begin
                    next_q.cnt = q.cnt + 1'b1;
                end
                // line high or 1 ms elapsed
                if (w_expired || (rb_used_i && q.cnt == CNT_W'(WB_CYC) && q.rb_s2)) begin
                    next_q.state     = S_IDLE;
                    next_q.init_done = 1'b1;
                    next_q.req_ready = 1'b1;
                    next_q.done      = 1'b1;
                end
            end
            S_IDLE: begin
                if (req_valid_i && q.req_ready) begin
                    if (busy_blocked(req_i.cmd) && q.busy) begin
                        next_q.err = 1'b1;
                    end else begin
                        // reset and status pass while busy
                        next_q.req       = req_i;
                        next_q.req_ready = 1'b0;
                        next_q.idx       = '0;
                        next_q           = launch(next_q, S_CMD);
                    end
                end
            end
            S_CMD, S_ADDR, S_DATA, S_CONF: begin
                if (q.state == S_CONF) begin
                    next_q.cnt = q.cnt + 1'b1;
                    if (q.cnt == CNT_W'(WP_CYC - 1)) begin
                        next_q.pin.we_n = 1'b1;
                    end
                end
                if (wr_last) begin
                    more = (q.state == S_ADDR && {1'b0, q.idx} + 3'h1 < {1'b0, q.req.n_addr})
                        || (q.state == S_DATA && {1'b0, q.idx} + 3'h1 < q.req.n_data);
                    if (q.state == S_CMD && q.req.cmd == CMD_RESET) begin
                        next_q.pin   = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                                         read_strobe_n: 1'b1, io: 8'h00, io_oe: 1'b0};
                        next_q.state = S_RST_WAIT;
                        next_q.cnt   = '0;
                        w_load       = 1'b1;
                        w_count      = T_RST_CYC;
                    end else if (more) begin
                        next_q.idx = q.idx + 1'b1;
                        next_q     = launch(next_q, q.state);
                    end else begin
                        next_q.idx = '0;
                        next_q     = launch(next_q, after(q));
                    end
                end
            end
            S_READ: begin
                next_q.cnt = q.cnt + 1'b1;
                if (q.cnt == CNT_W'(WHR_CYC - 1)) begin
                    next_q.pin.read_strobe_n = 1'b0;
                end
                if (q.cnt == CNT_W'(WHR_CYC + RP_CYC - 1)) begin
                    // status byte of the addressed die
                    next_q.pin.read_strobe_n = 1'b1;
                    next_q.rdata             = q.io_s2;
                    next_q.state             = S_FINISH;
                end
            end
            S_FINISH: begin
                next_q.pin.ce_n  = 1'b1;
                next_q.state     = S_IDLE;
                next_q.req_ready = 1'b1;
                next_q.done      = 1'b1;
            end
            default: begin
                next_q.state = S_PWR_START;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            q     <= '0;
            q.pin <= '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0, we_n: 1'b1,
                       read_strobe_n: 1'b1, io: 8'h00, io_oe: 1'b0};
        end else begin
            q <= next_q;
        end
    end

    assign req_ready_o     = q.req_ready;
    assign done_o          = q.done;
    assign err_o           = q.err;
    assign rdata_o         = q.rdata;
    assign init_done_o     = q.init_done;
    assign busy_o          = q.busy;
    assign ce_n_o          = q.pin.ce_n;
    assign cle_o           = q.pin.cle;
    assign ale_o           = q.pin.ale;
    assign we_n_o          = q.pin.we_n;
    assign read_strobe_n_o = q.pin.read_strobe_n;
    assign io_o            = q.pin.io;
    assign io_oe_o         = q.pin.io_oe;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    logic [WAIT_W-1:0] up_cyc;
    logic [WAIT_W-1:0] rst_cyc;
    logic              cmd_edge;
    assign cmd_edge = !q.pin.we_n && next_q.pin.we_n && q.pin.cle;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            up_cyc  <= '0;
            rst_cyc <= '0;
        end else begin
            if (up_cyc != '1) begin
                up_cyc <= up_cyc + 1'b1;
            end
            if (cmd_edge && q.pin.io == CMD_RESET) begin
                rst_cyc <= '0;
            end else if (rst_cyc != '1) begin
                rst_cyc <= rst_cyc + 1'b1;
            end
        end
    end

    sequence strobe_low;
        !we_n_o [*5];
    endsequence
    sequence strobe_high;
        we_n_o [*3];
    endsequence

    a_we_pulse_shape: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $fell(we_n_o) |-> strobe_low ##0 1'b1 ##1 strobe_high)
        else $error("write strobe low or high time wrong");
    a_cmd_latch_lines: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(we_n_o) && $past(cle_o) |-> $past(!ce_n_o && !ale_o && read_strobe_n_o && io_oe_o))
        else $error("command latched with wrong control lines");
    a_first_is_reset: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        cmd_edge && !init_done_o |-> io_o == CMD_RESET)
        else $error("first command is not reset");
    a_reset_after_valid: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        cmd_edge && !init_done_o |-> up_cyc >= T_VALID_CYC)
        else $error("reset issued before ready line valid");
    a_reset_line_high: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        cmd_edge && !init_done_o && rb_used_i |-> q.rb_s2)
        else $error("reset issued while ready line low");
    a_reset_busy_time: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(init_done_o) && !rb_used_i |-> rst_cyc >= T_RST_CYC)
        else $error("reset wait ended early");
    a_refuse_busy: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        q.state == S_IDLE && req_valid_i && req_ready_o && busy_o && busy_blocked(req_i.cmd)
        |=> err_o && req_ready_o)
        else $error("busy-sensitive command not refused");
    a_status_while_busy: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        q.state == S_IDLE && req_valid_i && req_ready_o
        && (req_i.cmd == CMD_STATUS || req_i.cmd == CMD_RESET)
        |=> !err_o && !req_ready_o ##0 !ce_n_o)
        else $error("status or reset refused");
    a_busy_view: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !ready_busy_n_i [*4] |-> busy_o)
        else $error("low ready line not seen as busy");

endmodule
`default_nettype wire

// ### core/nrbi_pkg.sv
package nrbi_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_RESET       = 8'hff;
    localparam logic [7:0] CMD_READ_ID     = 8'h90;
    localparam logic [7:0] CMD_PARAM_PAGE  = 8'hec;
    localparam logic [7:0] CMD_UNIQUE_ID   = 8'hed;
    localparam logic [7:0] CMD_GET_FEAT    = 8'hee;
    localparam logic [7:0] CMD_SET_FEAT    = 8'hef;
    localparam logic [7:0] CMD_STATUS      = 8'h70;
    localparam logic [7:0] CMD_STATUS_ENH  = 8'h78;
    localparam logic [7:0] CMD_RAND_READ   = 8'h05;
    localparam logic [7:0] CMD_RAND_CONF   = 8'he0;
    localparam logic [2:0] SET_FEAT_BYTES  = 3'h4;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int CLK_MHZ       = 200;
    localparam int T_WP_NS       = 25;
    localparam int T_WH_NS       = 15;
    localparam int T_WHR_NS      = 60;
    localparam int T_RP_NS       = 25;
    localparam int T_WB_NS       = 100;
    localparam int T_VALID_US    = 50;
    localparam int T_PWR_US      = 100;
    localparam int T_RST_US      = 1000;
    localparam int WP_CYC  = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WH_CYC  = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WHR_CYC = (T_WHR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RP_CYC  = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WB_CYC  = (T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_W  = 18;
    localparam int CNT_W   = 5;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  cmd;
        logic [1:0]  n_addr;
        logic [23:0] addr;
        logic [2:0]  n_data;
        logic [31:0] wdata;
        logic        conf_en;
        logic [7:0]  conf;
        logic        rd_en;
    } nrbi_req_t;

    typedef enum logic [3:0] {
        S_PWR_START, S_PWR_VALID, S_PWR_RDY, S_RST_WAIT, S_IDLE,
        S_CMD, S_ADDR, S_DATA, S_CONF, S_READ, S_FINISH
    } nrbi_state_t;

    typedef struct packed {
        logic        ce_n;
        logic        cle;
        logic        ale;
        logic        we_n;
        logic        read_strobe_n;
        logic [7:0]  io;
        logic        io_oe;
    } nrbi_pins_t;

endpackage

// ### core/nrbi_wait.sv
`timescale 1ns/1ps
`default_nettype none
module nrbi_wait
    import nrbi_pkg::*;
(
    input  wire logic              clk_sys_i,
    input  wire logic              rst_n_i,
    input  wire logic              load_i,
    input  wire logic [WAIT_W-1:0] count_i,
    output logic                   expired_o
);

    typedef struct packed {
        logic [WAIT_W-1:0] left;
    } nrbi_wait_st_t;

    nrbi_wait_st_t q;
    nrbi_wait_st_t next_q;

    always_comb begin
        next_q = q;
        if (load_i) begin
            next_q.left = count_i;
        end else if (q.left != '0) begin
            next_q.left = q.left - 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign expired_o = (q.left == '0);

endmodule
`default_nettype wire

// ### core/nrbi_host_unused_guard.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ### tb/nrbi_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module nrbi_dev_model
    import nrbi_pkg::*;
#(
    parameter int PWR_CYC  = 30,
    parameter int RST_BUSY = 60
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_n_i,
    input  wire logic       cle_i,
    input  wire logic       ale_i,
    input  wire logic       we_n_i,
    input  wire logic       read_strobe_n_i,
    input  wire logic [7:0] io_i,
    input  wire logic       io_oe_i,
    input  wire logic       die1_busy_i,
    output logic [7:0]      io_o,
    output logic            rb_pull_o,
    output logic [7:0]      last_cmd_o,
    output logic [7:0]      prev_cmd_o,
    output logic [7:0]      first_cmd_o,
    output int              n_cmd_o,
    output int              n_addr_o,
    output int              n_data_o,
    output logic            proto_err_o
);
    int         pwr_cnt;
    int         busy_cnt;
    logic       sel_die;
    logic [7:0] last_q;
    logic       die0_busy;
    logic       die1_busy;
    logic       drv;
    logic [7:0] stat;
    logic       we_q;
    logic       wr_edge;

    // ------------------------------------------------------------
    // Busy tracking
    // ------------------------------------------------------------
    assign die0_busy = (pwr_cnt < PWR_CYC) || (busy_cnt > 0);
    assign die1_busy = die0_busy || die1_busy_i;
    assign rb_pull_o = die0_busy || die1_busy;
    assign stat = sel_die ? {1'b1, !die1_busy, !die1_busy, 5'h00}
                          : {1'b1, !die0_busy, !die0_busy, 5'h00};
    assign drv  = !ce_n_i && !read_strobe_n_i && !io_oe_i;
    // Released lines show the inverse of the last level
    assign io_o = io_oe_i ? io_i : (drv ? stat : ~last_q);

    assign wr_edge = we_n_i && !we_q && !ce_n_i && read_strobe_n_i;

    // ------------------------------------------------------------
    // Latch cycles on rising write strobe
    // ------------------------------------------------------------
    // latch conditions, seen one clock after the strobe rises
    always @(posedge clk_sys_i) begin
        last_q <= io_o;
        we_q   <= we_n_i;
        if (!rst_n_i) begin
            pwr_cnt     <= 0;
            busy_cnt    <= 0;
            sel_die     <= 1'b0;
            n_cmd_o     <= 0;
            n_addr_o    <= 0;
            n_data_o    <= 0;
            first_cmd_o <= 8'h00;
            last_cmd_o  <= 8'h00;
            prev_cmd_o  <= 8'h00;
            proto_err_o <= 1'b0;
        end else begin
            if (pwr_cnt < PWR_CYC) pwr_cnt <= pwr_cnt + 1;
            if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
            if (wr_edge && cle_i && !ale_i) begin
                if (n_cmd_o == 0) first_cmd_o <= io_i;
                if (n_cmd_o == 0 && rb_pull_o) proto_err_o <= 1'b1;
                if (n_cmd_o == 0 && io_i != CMD_RESET) proto_err_o <= 1'b1;
                if (rb_pull_o && io_i inside {CMD_READ_ID, CMD_PARAM_PAGE, CMD_UNIQUE_ID,
                                               CMD_GET_FEAT, CMD_SET_FEAT}) proto_err_o <= 1'b1;
                if (die0_busy && io_i == CMD_RAND_READ) proto_err_o <= 1'b1;
                // reset always taken, wins over the countdown
                if (io_i == CMD_RESET) busy_cnt <= RST_BUSY;
                if (io_i == CMD_STATUS) sel_die <= 1'b0;
                if (io_i != CMD_RAND_CONF) begin
                    n_addr_o <= 0;
                    n_data_o <= 0;
                end
                prev_cmd_o <= last_cmd_o;
                last_cmd_o <= io_i;
                n_cmd_o    <= n_cmd_o + 1;
            end else if (wr_edge && ale_i && !cle_i) begin
                if (last_cmd_o == CMD_STATUS_ENH && n_addr_o == 2) sel_die <= io_i[0];
                n_addr_o <= n_addr_o + 1;
            end else if (wr_edge && !ale_i && !cle_i) begin
                n_data_o <= n_data_o + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/nand_ready_busy_init_cmdset_tb.sv
`timescale 1ns/1ps
`default_nettype none
module nand_ready_busy_init_cmdset_tb
    import nrbi_pkg::*;
;
    localparam int VALID_C = 20;
    localparam int PWR_C   = 40;
    localparam int RST_C   = 100;
    localparam int DEV_PWR = 30;
    localparam int DEV_RST = 60;

    logic       clk_sys;
    logic       rst_n;
    logic       rb_used;
    logic       req_valid;
    nrbi_req_t  req;
    logic       req_ready;
    logic       done;
    logic       err;
    logic [7:0] rdata;
    logic       init_done;
    logic       busy;
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       rd_n;
    logic [7:0] io_h;
    logic       io_oe;
    logic [7:0] io_d;
    logic       rb_pull;
    logic       ready_busy_n;
    logic       die1_busy;
    logic [7:0] last_cmd;
    logic [7:0] prev_cmd;
    logic [7:0] first_cmd;
    int         n_cmd;
    int         n_addr;
    int         n_data;
    logic       proto_err;
    int         err_total;
    int         n_tests;
    int         cyc;
    int         n;
    int         c0;
    logic [7:0] cmds [7] = '{CMD_READ_ID, CMD_PARAM_PAGE, CMD_UNIQUE_ID, CMD_GET_FEAT,
                            CMD_SET_FEAT, CMD_STATUS_ENH, CMD_RAND_READ};
    int         nas  [7] = '{1, 1, 1, 1, 1, 3, 2};
    int         nds  [7] = '{0, 0, 0, 0, 4, 0, 0};

    // Pull-up on the shared open-drain line
    assign ready_busy_n = !rb_pull;

    nrbi_host #(.T_VALID_CYC(WAIT_W'(VALID_C)), .T_PWR_CYC(WAIT_W'(PWR_C)),
                .T_RST_CYC(WAIT_W'(RST_C))) i_dut (
        .clk_sys_i(clk_sys), .rst_n_i(rst_n), .rb_used_i(rb_used), .req_valid_i(req_valid),
        .req_i(req), .req_ready_o(req_ready), .done_o(done), .err_o(err), .rdata_o(rdata),
        .init_done_o(init_done), .busy_o(busy), .ce_n_o(ce_n), .cle_o(cle), .ale_o(ale),
        .we_n_o(we_n), .read_strobe_n_o(rd_n), .io_o(io_h), .io_oe_o(io_oe), .io_i(io_d),
        .ready_busy_n_i(ready_busy_n));

    nrbi_dev_model #(.PWR_CYC(DEV_PWR), .RST_BUSY(DEV_RST)) i_dev (
        .clk_sys_i(clk_sys), .rst_n_i(rst_n), .ce_n_i(ce_n), .cle_i(cle), .ale_i(ale),
        .we_n_i(we_n), .read_strobe_n_i(rd_n), .io_i(io_h), .io_oe_i(io_oe),
        .die1_busy_i(die1_busy), .io_o(io_d), .rb_pull_o(rb_pull), .last_cmd_o(last_cmd),
        .prev_cmd_o(prev_cmd), .first_cmd_o(first_cmd), .n_cmd_o(n_cmd), .n_addr_o(n_addr),
        .n_data_o(n_data), .proto_err_o(proto_err));

    always #2.5 clk_sys = ~clk_sys;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Ceiling well above the whole sequence
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            finish_test();
        end
    end

    task automatic run_req(input logic [7:0] cmd, input logic [1:0] na, input logic [23:0] ad,
                           input logic [2:0] nd, input logic cf, input logic rd,
                           input logic exp_err, output int cnt);
        cnt = 0;
        while (req_ready !== 1'b1 && cnt < 2000) begin
            @(negedge clk_sys);
            cnt++;
        end
        req = '{cmd, na, ad, nd, 32'h44332211, cf, CMD_RAND_CONF, rd};
        req_valid = 1'b1;
        @(negedge clk_sys);
        req_valid = 1'b0;
        cnt = 0;
        while (done !== 1'b1 && err !== 1'b1 && cnt < 2000) begin
            @(negedge clk_sys);
            cnt++;
        end
        check("answer", 32'(done | err), 32'h1);
        check("refused", err, exp_err);
        // Keeps valid low for a full cycle between two calls
        @(negedge clk_sys);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_init(input logic mon, input int lo_first, input int lo_wait);
        int t;
        int t_first;
        @(negedge clk_sys);
        rb_used = mon;
        rst_n = 1'b0;
        repeat (20) @(negedge clk_sys);
        rst_n = 1'b1;
        t = 0;
        t_first = 0;
        while (init_done !== 1'b1 && t < 2000) begin
            @(negedge clk_sys);
            t++;
            if (n_cmd == 0) t_first = t;
        end
        check("first_cmd", first_cmd, CMD_RESET);
        check("first_wait", 32'(t_first >= lo_first), 32'h1);
        check("reset_wait", 32'(t - t_first >= lo_wait), 32'h1);
        check("init_done", init_done, 1'b1);
        check("rst_addr", n_addr, 0);
        check("proto", proto_err, 1'b0);
        $display("Test init monitor=%0d finished", mon);
    endtask

    task automatic t_cmdset();
        run_req(CMD_STATUS, 2'h0, 24'h000000, 3'h0, 1'b0, 1'b1, 1'b0, n);
        check("status", rdata, 8'he0);
        check("st_addr", n_addr, 0);
        for (int i = 0; i < 7; i++) begin
            run_req(cmds[i], 2'(nas[i]), 24'h000100, 3'(nds[i]), i == 6, 1'b0, 1'b0, n);
            check("n_addr", n_addr, nas[i]);
            check("n_data", n_data, nds[i]);
            check("cmd", (i == 6) ? prev_cmd : last_cmd, cmds[i]);
        end
        check("confirm", last_cmd, CMD_RAND_CONF);
        run_req(CMD_RESET, 2'h0, 24'h000000, 3'h0, 1'b0, 1'b0, 1'b0, n);
        check("rst_busy", 32'(n >= DEV_RST), 32'h1);
        check("rst_cmd", last_cmd, CMD_RESET);
        check("idle", busy, 1'b0);
        $display("Test command set finished");
    endtask

    task automatic t_busy();
        @(negedge clk_sys);
        die1_busy = 1'b1;
        n = 0;
        while (busy !== 1'b1 && n < 20) begin
            @(negedge clk_sys);
            n++;
        end
        check("busy", busy, 1'b1);
        c0 = n_cmd;
        run_req(CMD_READ_ID, 2'h1, 24'h000000, 3'h0, 1'b0, 1'b0, 1'b1, n);
        run_req(CMD_SET_FEAT, 2'h1, 24'h000000, 3'h4, 1'b0, 1'b0, 1'b1, n);
        run_req(CMD_RAND_READ, 2'h2, 24'h000000, 3'h0, 1'b1, 1'b0, 1'b1, n);
        check("no_send", n_cmd, c0);
        run_req(CMD_STATUS_ENH, 2'h3, 24'h000000, 3'h0, 1'b0, 1'b1, 1'b0, n);
        check("die0_st", rdata, 8'he0);
        run_req(CMD_STATUS_ENH, 2'h3, 24'h010000, 3'h0, 1'b0, 1'b1, 1'b0, n);
        check("die1_st", rdata, 8'h80);
        run_req(CMD_RESET, 2'h0, 24'h000000, 3'h0, 1'b0, 1'b0, 1'b0, n);
        check("busy_rst", last_cmd, CMD_RESET);
        check("timeout", 32'(n >= RST_C), 32'h1);
        check("proto", proto_err, 1'b0);
        die1_busy = 1'b0;
        $display("Test busy target finished");
    endtask

    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        rb_used = 1'b1;
        req_valid = 1'b0;
        req = '0;
        die1_busy = 1'b0;
        err_total = 0;
        n_tests = 0;
        cyc = 0;
        t_init(1'b1, DEV_PWR, DEV_RST);
        t_cmdset();
        t_busy();
        t_init(1'b0, VALID_C + PWR_C, RST_C);
        finish_test();
    end
endmodule
`default_nettype wire
